// File: inc/sam_pkg.sv
// Purpose: shared constants and types for the shift-add multiplier
// Assumes: 32-bit ahb-lite register bus, one word per register
// Notes: register offsets are byte addresses
package sam_pkg;
    localparam logic [7:0] OFS_RESULT = 8'h00;
    localparam logic [7:0] OFS_OPA = 8'h04;
    localparam logic [7:0] OFS_OPB = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0c;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int CTRL_START_BIT = 0;
    localparam logic [2:0] STEP_LAST = 3'h7;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic valid;
    } sam_req_type;

    typedef enum logic [1:0] {
        SAM_IDLE = 2'b01,
        SAM_RUN = 2'b10
    } sam_state_type;
endpackage : sam_pkg

// File: design/sam_selector.sv
// Purpose: partial-product selector for one step
// Assumes: step index 0..7
// Notes: purely combinational
`timescale 1ns/100ps
module sam_selector (
    input wire logic [7:0] op_a,
    input wire logic [7:0] op_b,
    input wire logic [2:0] step,
    output logic [15:0] partial
);
    always_comb begin
        if (op_b[step]) begin
            partial = {8'h00, op_a} << step;
        end else begin
            partial = 16'h0000;
        end
    end
endmodule : sam_selector

// File: design/sam_ahb_slave.sv
// Purpose: ahb-lite address-phase capture
// Assumes: single word transfers only
// Notes: zero wait states, always okay
`timescale 1ns/100ps
module sam_ahb_slave (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    output sam_pkg::sam_req_type req_r
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_r <= '0;
        end else if (hready) begin
            req_r.valid <= hsel && (htrans == sam_pkg::HTRANS_NONSEQ);
            req_r.addr <= haddr[7:0];
            req_r.write <= hwrite;
        end
    end
endmodule : sam_ahb_slave

// File: design/sam_multiplier.sv
// Purpose: 8x8 unsigned shift-and-add multiplier with ahb-lite registers
// Assumes: hclk is the cpu clock
// Notes: software clears the start bit after the counter reads 7
// What this block does
// - the product of two 8-bit unsigned operands appears as 16 bits in the result register.
// - setting the start bit clears the result and raises run on the next clock; counting and accumulation begin one clock later.
// - while running, each clock adds the selector output and steps the counter by one; at 7 the counter holds and step 7 is added once.
// - software clears start at count 7, after which the result is held unchanged.
// - while start is low, the counter and run stage stay cleared.
// - reset clears the control register to zero.
// - reset leaves the result register untouched.
// - reset leaves both operand registers untouched.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
module sam_multiplier (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic busy
);
    sam_pkg::sam_req_type req_r;
    logic [7:0] opa_r;
    logic [7:0] opb_r;
    logic [7:0] ctrl_r;
    logic [15:0] result_r;
    logic [2:0] step_r;
    logic run_r;
    logic [15:0] partial;
    logic start;
    logic result_done_r;
    // mark registers that hold a written value, so hold checks skip the undefined ones
    logic opa_loaded_r;
    logic opb_loaded_r;
    logic result_loaded_r;

    sam_ahb_slave u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .req_r(req_r)
    );

    sam_selector u_sel (
        .op_a(opa_r),
        .op_b(opb_r),
        .step(step_r),
        .partial(partial)
    );

    function automatic logic hit(input sam_pkg::sam_req_type r, input logic [7:0] ofs);
        hit = r.valid && r.write && (r.addr == ofs);
    endfunction : hit

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign start = ctrl_r[sam_pkg::CTRL_START_BIT];
    assign busy = run_r;

    // operands have no reset: undefined until written
    always_ff @(posedge hclk) begin
        if (hit(req_r, sam_pkg::OFS_OPA)) begin
            opa_r <= hwdata[7:0];
        end
        if (hit(req_r, sam_pkg::OFS_OPB)) begin
            opb_r <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= sam_pkg::CTRL_RESET;
        end else if (hit(req_r, sam_pkg::OFS_CTRL)) begin
            ctrl_r <= hwdata[7:0];
        end
    end

    // run stage: cleared whenever start is low, so the counter restarts at 0
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_r <= 1'b0;
            step_r <= 3'h0;
        end else if (!start) begin
            run_r <= 1'b0;
            step_r <= 3'h0;
        end else begin
            run_r <= 1'b1;
            if (run_r && step_r != sam_pkg::STEP_LAST) begin
                step_r <= step_r + 3'h1;
            end
        end
    end

    // result has no reset; cleared on start, then accumulated, then held
    always_ff @(posedge hclk) begin
        if (start && !run_r) begin
            result_r <= 16'h0000;
        end else if (run_r && start) begin
            if (step_r != sam_pkg::STEP_LAST || !result_done_r) begin
                result_r <= result_r + partial;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opa_loaded_r <= 1'b0;
            opb_loaded_r <= 1'b0;
            result_loaded_r <= 1'b0;
        end else begin
            if (hit(req_r, sam_pkg::OFS_OPA)) begin
                opa_loaded_r <= 1'b1;
            end
            if (hit(req_r, sam_pkg::OFS_OPB)) begin
                opb_loaded_r <= 1'b1;
            end
            if (start && !run_r) begin
                result_loaded_r <= 1'b1;
            end
        end
    end

    // marks that step 7 was added, so holding start longer adds nothing more
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_done_r <= 1'b0;
        end else if (!start) begin
            result_done_r <= 1'b0;
        end else if (run_r && step_r == sam_pkg::STEP_LAST) begin
            result_done_r <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans == sam_pkg::HTRANS_NONSEQ && !hwrite) begin
            case (haddr[7:0])
                sam_pkg::OFS_RESULT: hrdata <= {16'h0000, result_r};
                sam_pkg::OFS_OPA: hrdata <= {24'h000000, opa_r};
                sam_pkg::OFS_OPB: hrdata <= {24'h000000, opb_r};
                sam_pkg::OFS_CTRL: hrdata <= {24'h000000, ctrl_r[7:4], step_r, start};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    a_start_begins: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(start) |=> run_r && step_r == 3'h0)
        else $error("run did not begin after start");
    a_step_advance: assert property (@(posedge hclk) disable iff (!hresetn)
        run_r && start && step_r != 3'h7 |=> step_r == $past(step_r) + 3'h1)
        else $error("counter did not advance by one");
    a_idle_cleared: assert property (@(posedge hclk) disable iff (!hresetn)
        !start |=> step_r == 3'h0 && !run_r)
        else $error("counter not cleared while idle");
    a_result_held: assert property (@(posedge hclk) disable iff (!hresetn)
        result_loaded_r && !start && !$past(start) |=> $stable(result_r))
        else $error("result changed while stopped");
    a_ctrl_reset: assert property (@(posedge hclk)
        !hresetn |-> ctrl_r == 8'h00)
        else $error("control not zero in reset");
    a_product_final: assert property (@(posedge hclk) disable iff (!hresetn)
        run_r && start && step_r == 3'h7 && !result_done_r |=>
        result_r == 16'(opa_r) * 16'(opb_r))
        else $error("final product wrong");
    a_partial_sel: assert property (@(posedge hclk) disable iff (!hresetn)
        run_r && !opb_r[step_r] |-> partial == 16'h0000)
        else $error("selector passed a zero bit");
    a_operand_kept: assert property (@(posedge hclk) disable iff (!hresetn)
        opa_loaded_r && !hit(req_r, sam_pkg::OFS_OPA) |=> $stable(opa_r))
        else $error("operand a changed without write");
    a_opb_kept: assert property (@(posedge hclk) disable iff (!hresetn)
        opb_loaded_r && !hit(req_r, sam_pkg::OFS_OPB) |=> $stable(opb_r))
        else $error("operand b changed without write");
    a_result_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
        result_loaded_r && !start |=> $stable(result_r))
        else $error("result changed while start low");
    a_busy_run: assert property (@(posedge hclk) disable iff (!hresetn)
        start && !run_r |=> busy)
        else $error("busy not raised after start");
endmodule : sam_multiplier

// File: verification/shift_add_multiplier_8x8_bench.sv
// Purpose: self-checking bench for the shift-add multiplier
// Assumes: zero-wait ahb-lite slave, hready looped from hreadyout
// Notes: no partner model; the bench is the bus master
`timescale 1ns/100ps
module shift_add_multiplier_8x8_bench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic busy;
    logic [31:0] hrdata;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    assign hready = hreadyout;
    sam_multiplier i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .busy(busy));
    initial begin
        forever #5 hclk = ~hclk;
    end
    // generous ceiling: the whole run needs well under 2000 cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            $display("[FAIL] %0t timeout", $time);
            final_report();
        end
    end
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    // entered just after a rising edge; returns at the edge that ends the data phase
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
            output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= sam_pkg::HTRANS_NONSEQ;
        haddr <= {24'h0, addr};
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : bus
    task automatic test_reset();
        logic [31:0] r;
        bus(1'b0, sam_pkg::OFS_CTRL, 32'h0, r);
        check(r, 32'h0, "control after reset");
        check({31'h0, busy}, 32'h0, "busy after reset");
        check({31'h0, hresp}, 32'h0, "response okay");
        bus(1'b1, 8'h10, 32'h5a, r);
        bus(1'b0, 8'h10, 32'h0, r);
        check(r, 32'h0, "unmapped read");
        $display("test reset done");
    endtask : test_reset
    task automatic test_mul(input logic [7:0] a, input logic [7:0] b);
        logic [31:0] r;
        int k;
        bus(1'b1, sam_pkg::OFS_OPA, {24'h0, a}, r);
        bus(1'b1, sam_pkg::OFS_OPB, {24'h0, b}, r);
        bus(1'b1, sam_pkg::OFS_CTRL, 32'h1, r);
        k = 0;
        r = 32'h0;
        while (r[3:1] !== sam_pkg::STEP_LAST && k < 30) begin
            bus(1'b0, sam_pkg::OFS_CTRL, 32'h0, r);
            check({31'h0, r[0]}, 32'h1, "start bit stays set");
            k++;
        end
        check({29'h0, r[3:1]}, 32'h7, "counter reaches last step");
        check({31'h0, busy}, 32'h1, "busy while running");
        bus(1'b1, sam_pkg::OFS_CTRL, 32'h0, r);
        bus(1'b0, sam_pkg::OFS_RESULT, 32'h0, r);
        check(r, 32'(a) * 32'(b), "product");
        repeat (4) @(posedge hclk);
        bus(1'b0, sam_pkg::OFS_RESULT, 32'h0, r);
        check(r, 32'(a) * 32'(b), "product held after stop");
        bus(1'b0, sam_pkg::OFS_CTRL, 32'h0, r);
        check(r, 32'h0, "counter cleared while stopped");
        check({31'h0, busy}, 32'h0, "idle after stop");
        $display("test mul %h x %h done", a, b);
    endtask : test_mul
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_reset();
        test_mul(8'haa, 8'hd3);
        test_mul(8'hff, 8'hff);
        test_mul(8'h00, 8'hff);
        test_mul(8'h01, 8'h80);
        test_mul(8'h80, 8'h01);
        test_mul(8'h5b, 8'h00);
        final_report();
    end
endmodule : shift_add_multiplier_8x8_bench
